// ### rtl/ims_master.sv
// Master-mode engine of a two-wire serial port with register port and interrupt
`timescale 1ns/1ns
`include "ims_params.svh"

// Overview of operation
// - Master makes all clocks, starts, stops
// - Transfer ends by stop or repeated start
// - Write address byte ends in bit 0
// - Send eight bits, slave acknowledges
// - Read address byte ends in bit 1
// - Sample eight bits while driving clock
// - Master answers each received byte with control bit 5
// - Clock rate from shared baud generator
// - Start request bit 0 makes start
// - Flag after start, after hold time
// - Address written to buffer shifts out
// - Data written to buffer shifts out
// - Slave acknowledge stored in bit 6
// - Flag set end of ninth clock
// - Stop request bit 2 makes stop
// - Interrupt once stop has completed
module ims_master (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Bus pins, open drain
  input wire logic bus_clock_line_in,
  output logic bus_clock_line_out,
  output logic bus_clock_line_oe,
  input wire logic bus_data_line_in,
  output logic bus_data_line_out,
  output logic bus_data_line_oe
);
  typedef struct packed {
    ims_pkg::ims_phase_t phase;
    logic [1:0] quarter;
    logic [3:0] bitn;
    logic recv;
    logic [7:0] shift_buffer_reg;
    logic [7:0] serial_control_two;
    logic [7:0] baud;
    logic [3:0] status;
    logic [3:0] mask;
    logic scl;
    logic sda;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [7:0] rdata;
  } ims_state_t;

  ims_state_t st_ff;
  ims_state_t nxt_st;
  ims_tick_if tk ();

  ims_baud_gen u_baud (
    .ref_clk(ref_clk),
    .reset(reset),
    .tk(tk)
  );

  // Sequencer runs the generator only while a bus phase is active
  assign tk.run = st_ff.phase != ims_pkg::IMS_PH_IDLE;
  assign tk.reload = st_ff.baud;

  function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] wr);
    w1c = cur & ~wr;
  endfunction

  always_comb begin
    // Status bits raised by the bus engine this cycle
    logic [3:0] hw_set;
    hw_set = 4'h0;
    nxt_st = st_ff;
    nxt_st.scl_sync = {st_ff.scl_sync[0], bus_clock_line_in};
    nxt_st.sda_sync = {st_ff.sda_sync[0], bus_data_line_in};
    nxt_st.rdata = 8'h00;
    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        `IMS_ADDR_BUF: nxt_st.rdata = st_ff.shift_buffer_reg;
        `IMS_ADDR_CON2: nxt_st.rdata = st_ff.serial_control_two;
        `IMS_ADDR_BAUD: nxt_st.rdata = st_ff.baud;
        `IMS_ADDR_STAT: nxt_st.rdata = {4'h0, st_ff.status};
        `IMS_ADDR_MASK: nxt_st.rdata = {4'h0, st_ff.mask};
        `IMS_ADDR_FLAGS: nxt_st.rdata = {6'h00, st_ff.recv,
                                         st_ff.phase != ims_pkg::IMS_PH_IDLE};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `IMS_ADDR_BUF: begin
          if (st_ff.phase == ims_pkg::IMS_PH_IDLE) begin
            nxt_st.shift_buffer_reg = reg_wdata;
            nxt_st.recv = 1'b0;
            nxt_st.phase = ims_pkg::IMS_PH_BYTE;
            nxt_st.bitn = 4'h0;
            nxt_st.quarter = 2'h0;
          end
        end
        `IMS_ADDR_CON2: begin
          nxt_st.serial_control_two[5:0] = reg_wdata[5:0];
        end
        `IMS_ADDR_BAUD: nxt_st.baud = reg_wdata;
        `IMS_ADDR_MASK: nxt_st.mask = reg_wdata[3:0];
        default: ;
      endcase
    end
    // Launch a queued request when idle
    if (st_ff.phase == ims_pkg::IMS_PH_IDLE) begin
      if (st_ff.serial_control_two[`IMS_CON2_START_REQ_BIT]
          || st_ff.serial_control_two[`IMS_CON2_RESTART_REQ_BIT]) begin
        nxt_st.phase = ims_pkg::IMS_PH_START;
        nxt_st.quarter = 2'h0;
      end else if (st_ff.serial_control_two[`IMS_CON2_STOP_REQ_BIT]) begin
        nxt_st.phase = ims_pkg::IMS_PH_STOP;
        nxt_st.quarter = 2'h0;
      end else if (st_ff.serial_control_two[`IMS_CON2_RECV_EN_BIT]) begin
        nxt_st.phase = ims_pkg::IMS_PH_BYTE;
        nxt_st.recv = 1'b1;
        nxt_st.bitn = 4'h0;
        nxt_st.quarter = 2'h0;
        nxt_st.shift_buffer_reg = 8'hff;
      end
    end else if (tk.tick) begin
      nxt_st.quarter = st_ff.quarter + 2'h1;
      unique case (st_ff.phase)
        ims_pkg::IMS_PH_START: begin
          // Q0 release data, Q1 clock high, Q2 data low, Q3 hold then clock low
          unique case (st_ff.quarter)
            2'h0: nxt_st.sda = 1'b1;
            2'h1: nxt_st.scl = 1'b1;
            2'h2: nxt_st.sda = 1'b0;
            2'h3: begin
              nxt_st.scl = 1'b0;
              nxt_st.phase = ims_pkg::IMS_PH_IDLE;
              hw_set[`IMS_ST_START] = 1'b1;
              nxt_st.serial_control_two[`IMS_CON2_START_REQ_BIT] = 1'b0;
              nxt_st.serial_control_two[`IMS_CON2_RESTART_REQ_BIT] = 1'b0;
            end
          endcase
        end
        ims_pkg::IMS_PH_BYTE: begin
          unique case (st_ff.quarter)
            2'h0: begin
              if (st_ff.bitn == 4'h8) begin
                // Ninth clock: drive ack when receiving, else release
                nxt_st.sda = st_ff.recv ? st_ff.serial_control_two[`IMS_CON2_ACK_VAL_BIT]
                                        : 1'b1;
              end else begin
                // Bit 0 of buffer is the read/write bit of the address byte
                nxt_st.sda = st_ff.recv ? 1'b1 : st_ff.shift_buffer_reg[7];
              end
            end
            2'h1: nxt_st.scl = 1'b1;
            2'h2: begin
              if (st_ff.scl_sync[1]) begin
                if (st_ff.bitn == 4'h8) begin
                  if (!st_ff.recv) begin
                    nxt_st.serial_control_two[`IMS_CON2_ACK_SEEN_BIT] =
                      st_ff.sda_sync[1];
                  end
                end else begin
                  nxt_st.shift_buffer_reg = {st_ff.shift_buffer_reg[6:0],
                                             st_ff.sda_sync[1]};
                end
              end else begin
                // Slave stretches the clock
                nxt_st.quarter = st_ff.quarter;
              end
            end
            2'h3: begin
              nxt_st.scl = 1'b0;
              nxt_st.bitn = st_ff.bitn + 4'h1;
              if (st_ff.bitn == 4'h8) begin
                nxt_st.phase = ims_pkg::IMS_PH_IDLE;
                nxt_st.sda = st_ff.recv ? 1'b1 : st_ff.sda;
                hw_set[`IMS_ST_BYTE] = 1'b1;
                nxt_st.serial_control_two[`IMS_CON2_RECV_EN_BIT] = 1'b0;
                if (st_ff.recv) begin
                  hw_set[`IMS_ST_ACK] = 1'b1;
                end
              end
            end
          endcase
        end
        ims_pkg::IMS_PH_STOP: begin
          unique case (st_ff.quarter)
            2'h0: nxt_st.sda = 1'b0;
            2'h1: nxt_st.scl = 1'b1;
            2'h2: nxt_st.sda = 1'b1;
            2'h3: begin
              nxt_st.phase = ims_pkg::IMS_PH_IDLE;
              hw_set[`IMS_ST_STOP] = 1'b1;
              nxt_st.serial_control_two[`IMS_CON2_STOP_REQ_BIT] = 1'b0;
            end
          endcase
        end
        default: ;
      endcase
    end
    // Hardware sets win over a same-cycle software clear
    nxt_st.status = st_ff.status | hw_set;
    if (reg_wr && reg_addr == `IMS_ADDR_STAT) begin
      nxt_st.status = w1c(st_ff.status, reg_wdata[3:0]) | hw_set;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);
  // Open drain: drive low only
  assign bus_clock_line_out = 1'b0;
  assign bus_clock_line_oe = ~st_ff.scl;
  assign bus_data_line_out = 1'b0;
  assign bus_data_line_oe = ~st_ff.sda;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Lines released, generator at its reset rate
      st_ff <= '{
        phase: ims_pkg::IMS_PH_IDLE,
        quarter: 2'h0,
        bitn: 4'h0,
        recv: 1'b0,
        shift_buffer_reg: 8'h00,
        serial_control_two: 8'h00,
        baud: `IMS_BAUD_RESET,
        status: 4'h0,
        mask: 4'h0,
        scl: 1'b1,
        sda: 1'b1,
        scl_sync: 2'b11,
        sda_sync: 2'b11,
        rdata: 8'h00
      };
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // ims_master

// ### rtl/ims_params.svh
// Offsets, field positions, reset values and timing counts of the I2C master sequencer
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH
`define IMS_ADDR_BUF 4'h0
`define IMS_ADDR_CON2 4'h1
`define IMS_ADDR_BAUD 4'h2
`define IMS_ADDR_STAT 4'h3
`define IMS_ADDR_MASK 4'h4
`define IMS_ADDR_FLAGS 4'h5
`define IMS_CON2_START_REQ_BIT 0
`define IMS_CON2_RESTART_REQ_BIT 1
`define IMS_CON2_STOP_REQ_BIT 2
`define IMS_CON2_RECV_EN_BIT 3
`define IMS_CON2_ACK_EN_BIT 4
`define IMS_CON2_ACK_VAL_BIT 5
`define IMS_CON2_ACK_SEEN_BIT 6
`define IMS_ST_START 0
`define IMS_ST_BYTE 1
`define IMS_ST_STOP 2
`define IMS_ST_ACK 3
`define IMS_CLK_HZ 100000000
`define IMS_RATE_100K 100000
`define IMS_BAUD_RESET 8'hf9
`define IMS_BAUD_DIV(rate) ((`IMS_CLK_HZ / (4 * (rate))) - 1)
`endif

// ### rtl/ims_pkg.sv
// Types of the I2C master sequencer
package ims_pkg;
  typedef enum logic [1:0] {
    IMS_PH_IDLE,
    IMS_PH_START,
    IMS_PH_BYTE,
    IMS_PH_STOP
  } ims_phase_t;
endpackage

// ### rtl/ims_tick_if.sv
// Quarter-period tick carrier between the sequencer and its baud generator
`timescale 1ns/1ns
interface ims_tick_if;
  logic run;
  logic [7:0] reload;
  logic tick;
  modport gen (input run, input reload, output tick);
  modport seq (output run, output reload, input tick);
endinterface

// ### rtl/ims_baud_gen.sv
// Baud rate generator: one tick every reload+1 clocks while running
`timescale 1ns/1ns
module ims_baud_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Tick carrier
  ims_tick_if.gen tk
);
  typedef struct packed {
    logic [7:0] cnt;
  } ims_bg_state_t;
  ims_bg_state_t st_ff;
  ims_bg_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!tk.run || st_ff.cnt == 8'h00) begin
      nxt_st.cnt = tk.reload;
    end else begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end
  end

  assign tk.tick = tk.run && st_ff.cnt == 8'h00;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // ims_baud_gen

// ### tb/ims_master_chk.sv
// Port-level assertions of the I2C master sequencer
`timescale 1ns/1ns
module ims_master_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port and interrupt
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  // Bus pins
  input wire logic bus_clock_line_out,
  input wire logic bus_clock_line_oe,
  input wire logic bus_data_line_out,
  input wire logic bus_data_line_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_rst;
    disable iff (1'b0) reset |=> !bus_clock_line_oe && !bus_data_line_oe && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("Busy after reset");
  property p_rdata;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("Read data outside slot");
  property p_od;
    !bus_clock_line_out && !bus_data_line_out;
  endproperty
  a_od: assert property (p_od) else $error("Pin driven high");
  property p_start;
    $rose(bus_data_line_oe) && !bus_clock_line_oe |=>
      bus_data_line_oe throughout (##[0:1000] bus_clock_line_oe);
  endproperty
  a_start: assert property (p_start) else $error("Start hold broken");
  property p_req_start;
    reg_wr && reg_addr == 4'h1 && reg_wdata[0] |->
      ##[1:1000] ($rose(bus_data_line_oe) && !bus_clock_line_oe);
  endproperty
  a_req_start: assert property (p_req_start) else $error("No start");
  property p_req_stop;
    reg_wr && reg_addr == 4'h1 && reg_wdata[2] |->
      ##[1:1000] ($fell(bus_data_line_oe) && !bus_clock_line_oe);
  endproperty
  a_req_stop: assert property (p_req_stop) else $error("No stop");
  property p_stop_idle;
    $fell(bus_data_line_oe) && !bus_clock_line_oe |=> !bus_clock_line_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Bus not idle");
  property p_mask;
    reg_wr && reg_addr == 4'h4 && reg_wdata == 8'h00 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("Masked irq high");
endmodule // ims_master_chk
bind ims_master ims_master_chk i_ims_master_chk (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .bus_clock_line_out(bus_clock_line_out),
  .bus_clock_line_oe(bus_clock_line_oe), .bus_data_line_out(bus_data_line_out),
  .bus_data_line_oe(bus_data_line_oe));

// ### tb/ims_slave_model.sv
// Behavioural slave: acks its address, answers reads
`timescale 1ns/1ns
module ims_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] RD_BYTE = 8'hc5
) (
  // Wired bus levels
  input wire logic scl,
  input wire logic sda,
  // Data pull-down
  output logic sda_oe
);
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic first = 1'b0, rd = 1'b0;
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl) begin
    cnt = 4'h0;
    first = 1'b1;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 4'h1;
  end
  // Changes only while the clock is low
  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (cnt == 4'h8 && first) begin
      sda_oe = sh[7:1] == ADDR;
      rd = sda_oe && sh[0];
    end else if (cnt == 4'h8 && !rd) begin
      sda_oe = 1'b1;
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      first = 1'b0;
      rd = rd && !sh[0];
      sda_oe = rd && !RD_BYTE[7];
    end else if (rd && !first && cnt < 4'h8) begin
      sda_oe = !RD_BYTE[3'(4'h7 - cnt)];
    end
  end
endmodule // ims_slave_model

// ### tb/test_i2c_master_sequencer.sv
// Self-checking bench of the I2C master sequencer
`timescale 1ns/1ns
module test_i2c_master_sequencer;
  typedef struct {string n; logic [7:0] e; logic [7:0] m;} ims_note_t;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [8:0] bits;
  logic irq, scl_oe, sda_oe, s_oe, scl_w, sda_w;
  int failures = 0, n_checks = 0;
  integer seed = 56473;
  ims_note_t q[$];
  // Open-drain lines with pull-ups
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || s_oe);
  ims_master i_ims_master (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .bus_clock_line_in(scl_w), .bus_clock_line_out(),
    .bus_clock_line_oe(scl_oe), .bus_data_line_in(sda_w), .bus_data_line_out(),
    .bus_data_line_oe(sda_oe));
  ims_slave_model i_ims_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe(s_oe));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge scl_w) bits <= {bits[7:0], sda_w};
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      chk(q[0].n, reg_rdata & q[0].m, q[0].e);
      void'(q.pop_front());
    end
  end
  task automatic wrap_up();
    $display("Counts: %0d compared, %0d wrong", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m, string n);
    q.push_back('{n, e, m});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge ref_clk);
    if (irq !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask
  // Request, wait for the flag, check status and control, clear
  task automatic step(logic [3:0] a, logic [7:0] v, logic [7:0] st, logic [7:0] sm,
      logic [7:0] ce, logic [7:0] cm);
    bus(1'b1, a, v);
    wait_irq();
    rd(4'h3, st, sm, "status");
    rd(4'h1, ce, cm, "control");
    bus(1'b1, 4'h3, 8'hff);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h2, 8'hf9, 8'hff, "baud");
    rd(4'h3, 8'h00, 8'hff, "status");
    rd(4'he, 8'h00, 8'hff, "unmapped");
    bus(1'b1, 4'h2, 8'h03);
    bus(1'b1, 4'h4, 8'h0f);
    $display("Reset test done");
    step(4'h1, 8'h01, 8'h01, 8'hff, 8'h00, 8'h0f);
    step(4'h0, 8'h54, 8'h02, 8'hff, 8'h00, 8'h4f);
    chk("address out", bits[8:1], 8'h54);
    d = 8'($random(seed));
    step(4'h0, d, 8'h02, 8'hff, 8'h00, 8'h4f);
    chk("data out", bits[8:1], d);
    $display("Write test done");
    bus(1'b1, 4'h1, 8'h02);
    wait_irq();
    bus(1'b1, 4'h4, 8'h00);
    @(negedge ref_clk);
    chk("masked irq", {7'h00, irq}, 8'h00);
    rd(4'h3, 8'h01, 8'hff, "restart");
    bus(1'b1, 4'h4, 8'h0f);
    bus(1'b1, 4'h3, 8'hff);
    step(4'h0, 8'h55, 8'h02, 8'hff, 8'h00, 8'h4f);
    chk("read address", bits[8:1], 8'h55);
    for (int k = 0; k < 2; k++) begin
      step(4'h1, {2'h0, k[0], 5'h08}, 8'h08, 8'h08, 8'h00, 8'h0f);
      rd(4'h0, 8'hc5, 8'hff, "received");
      chk("master ack", {7'h00, bits[0]}, {7'h00, k[0]});
    end
    step(4'h1, 8'h04, 8'h04, 8'hff, 8'h00, 8'h0f);
    chk("idle lines", {6'h00, scl_w, sda_w}, 8'h03);
    $display("Read test done");
    step(4'h1, 8'h01, 8'h01, 8'hff, 8'h00, 8'h0f);
    step(4'h0, 8'h10, 8'h02, 8'hff, 8'h40, 8'h4f);
    step(4'h1, 8'h04, 8'h04, 8'hff, 8'h00, 8'h0f);
    $display("Nack test done");
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule // test_i2c_master_sequencer
